// ---- hdl/asp_pkg.sv ----
`default_nettype none
package asp_pkg;

  // Control register bit positions.
  localparam int CTL_MODE = 7;
  localparam int CTL_ONE  = 6;
  localparam int CTL_FILT = 5;
  localparam int CTL_REN  = 4;
  localparam int CTL_TB8  = 3;
  localparam int CTL_RB8  = 2;
  localparam int CTL_TI   = 1;
  localparam int CTL_RI   = 0;

  localparam logic [7:0] CTL_RST = 8'h40;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] TMR_RST = 8'h00;
  localparam logic [7:0] TMR_TOP = 8'hff;

  // Timer clock source codes.
  localparam logic [2:0] SRC_SYS   = 3'h0;
  localparam logic [2:0] SRC_DIV4  = 3'h1;
  localparam logic [2:0] SRC_DIV12 = 3'h2;
  localparam logic [2:0] SRC_DIV48 = 3'h3;
  localparam logic [2:0] SRC_EXT8  = 3'h4;
  localparam logic [2:0] SRC_PIN   = 3'h5;

  // Shared prescaler counts 0..47; the divide taps sit on its last counts.
  localparam logic [5:0] PRE_TOP   = 6'h2f;
  localparam logic [1:0] DIV4_TAP  = 2'h3;
  localparam logic [5:0] DIV12_TP0 = 6'h0b;
  localparam logic [5:0] DIV12_TP1 = 6'h17;
  localparam logic [5:0] DIV12_TP2 = 6'h23;
  localparam logic [2:0] EXT8_TAP  = 3'h7;
  localparam logic [3:0] LAST_DATA = 4'h7;

  typedef struct packed {
    logic mode;
    logic one;
    logic filt;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } asp_ctl_t;

  typedef struct packed {
    logic       run;
    logic [2:0] src;
    logic [7:0] reload;
  } asp_tmr_cfg_t;

  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_WAIT  = 6'h02,
    TX_START = 6'h04,
    TX_DATA  = 6'h08,
    TX_NINTH = 6'h10,
    TX_STOP  = 6'h20
  } asp_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_NINTH = 5'h08,
    RX_STOP  = 5'h10
  } asp_rx_st_t;

endpackage
`default_nettype wire

// ---- hdl/asp_baud_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module asp_baud_timer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [7:0] reload,
  input  wire logic       force_reload,
  output var  logic       bit_tick_r
);
  import asp_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       phase_r;
  logic       phase_nxt;
  logic       bit_nxt;
  logic       ovf;

  // Overflows are halved: only every other one becomes a bit tick.
  always_comb begin
    cnt_nxt   = cnt_r;
    phase_nxt = phase_r;
    ovf       = run && tick && (cnt_r == TMR_TOP);
    bit_nxt   = 1'b0;
    if (force_reload) begin
      cnt_nxt   = reload;
      phase_nxt = 1'b0;
    end else if (run && tick) begin
      cnt_nxt   = ovf ? reload : cnt_r + 8'h01;
      phase_nxt = ovf ? ~phase_r : phase_r;
      bit_nxt   = ovf && !phase_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= TMR_RST;
      phase_r    <= 1'b0;
      bit_tick_r <= 1'b0;
    end else if (ce) begin
      cnt_r      <= cnt_nxt;
      phase_r    <= phase_nxt;
      bit_tick_r <= bit_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/asp_serial_port.sv ----
// Overview of operation
// - Transmitter and receiver run independently and concurrently, full duplex.
// - Control bit 7 selects 8-bit framing at 0, 9-bit at 1.
// - Buffer write loads transmit data; buffer read shows receive holding byte.
// - Receive shift register is separate from the holding register.
// - Interrupt request rises when enabled and either done flag is set.
// - Done flags are cleared only by software writes, never by hardware.
// - Transmit bit clock from timer overflows; receive from a hidden copy.
// - Both timer overflow rates are halved to make the bit rate.
// - Receive timer copy runs with the timer and reloads at a start edge.
// - Timer clock picks system clock, /4, /12, /48, external oscillator /8, or pin.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 8-bit mode stores data in holding register and stop bit in bit 2.
// - Buffer write starts transmission; transmit-done sets at stop-bit start.
// - Frame reception starts only while the receive enable bit is 1.
// - 8-bit accept needs receive-done 0, and stop 1 if filter set.
// - Accept loads data, ninth bit, sets receive-done; reject changes nothing.
// - On overrun the held byte stays and the new frame is lost.
// - 9-bit frame: start, eight data bits LSB first, ninth bit, stop.
// - Transmitted ninth bit is the control register bit 3.
// - 9-bit mode stores the ninth bit in bit 2 and ignores stop.
// - 9-bit accept needs receive-done 0, and ninth bit 1 if filter set.
// - Receive-done sets when the stop bit is sampled and accepted.
// - Control bit 6 always reads 1; writes to it are ignored.
`timescale 1ns/10ps
`default_nettype none
module asp_serial_port (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic                  ctl_wr,
  input  wire asp_pkg::asp_ctl_t     ctl_wdata,
  input  wire logic                  buf_wr,
  input  wire logic [7:0]            buf_wdata,
  input  wire asp_pkg::asp_tmr_cfg_t tmr_cfg,
  input  wire logic                  irq_en,
  input  wire logic                  ext_osc_in,
  input  wire logic                  timer_ext_input,
  input  wire logic                  serial_in_pin,
  output var  logic                  serial_out_pin,
  output var  asp_pkg::asp_ctl_t     serial_control_reg,
  output var  logic [7:0]            serial_buffer_reg,
  output var  logic                  irq_req,
  output var  logic                  tx_busy
);
  import asp_pkg::*;

  logic           rst_q1_r;
  logic           rst_n_s;
  logic [2:0]     sync1_r;
  logic [2:0]     sync2_r;
  logic [2:0]     prev_r;
  logic           rx_in;
  logic           ext_edge;
  logic           pin_edge;
  logic [5:0]     pre_r;
  logic [5:0]     pre_nxt;
  logic [2:0]     ext_cnt_r;
  logic [2:0]     ext_cnt_nxt;
  logic           tmr_tick;
  logic           tx_bit_r;
  logic           rx_bit_r;
  logic           tx_tick;
  logic           rx_tick;
  asp_tx_st_t     tx_st_r;
  asp_tx_st_t     tx_st_nxt;
  logic [7:0]     tx_sh_r;
  logic [7:0]     tx_sh_nxt;
  logic           tx_nine_r;
  logic           tx_nine_nxt;
  logic           tx_mode_r;
  logic           tx_mode_nxt;
  logic [3:0]     tx_cnt_r;
  logic [3:0]     tx_cnt_nxt;
  logic           tx_out_nxt;
  logic           tx_set_ti;
  asp_rx_st_t     rx_st_r;
  asp_rx_st_t     rx_st_nxt;
  logic [7:0]     rx_sh_r;
  logic [7:0]     rx_sh_nxt;
  logic           rx_nine_r;
  logic           rx_nine_nxt;
  logic [3:0]     rx_cnt_r;
  logic [3:0]     rx_cnt_nxt;
  logic           rx_force;
  logic           rx_done;
  logic           rx_check;
  logic           rx_accept;
  asp_ctl_t       ctl_r;
  asp_ctl_t       ctl_nxt;
  logic [7:0]     hold_r;
  logic [7:0]     hold_nxt;
  logic           irq_nxt;

  // Reset asserts at once but releases through two flops.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1_r <= 1'b0;
      rst_n_s  <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n_s  <= rst_q1_r;
    end
  end

  // Pins are synchronised; edge detectors compare the second stage with its delayed copy in prev_r.
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      prev_r  <= 3'h7;
    end else if (clk_en) begin
      sync1_r <= {serial_in_pin, timer_ext_input, ext_osc_in};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rx_in    = sync2_r[2];
  assign ext_edge = sync2_r[0] && !prev_r[0];
  assign pin_edge = sync2_r[1] && !prev_r[1];

  // The external oscillator must be well below half sys_clk to be counted.
  always_comb begin
    pre_nxt     = (pre_r == PRE_TOP) ? 6'h00 : pre_r + 6'h01;
    ext_cnt_nxt = ext_edge ? ext_cnt_r + 3'h1 : ext_cnt_r;
    case (tmr_cfg.src)
      SRC_SYS:   tmr_tick = 1'b1;
      SRC_DIV4:  tmr_tick = (pre_r[1:0] == DIV4_TAP);
      SRC_DIV12: tmr_tick = (pre_r == DIV12_TP0) || (pre_r == DIV12_TP1) ||
                            (pre_r == DIV12_TP2) || (pre_r == PRE_TOP);
      SRC_DIV48: tmr_tick = (pre_r == PRE_TOP);
      SRC_EXT8:  tmr_tick = ext_edge && (ext_cnt_r == EXT8_TAP);
      SRC_PIN:   tmr_tick = pin_edge;
      default:   tmr_tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pre_r     <= 6'h00;
      ext_cnt_r <= 3'h0;
    end else if (clk_en) begin
      pre_r     <= pre_nxt;
      ext_cnt_r <= ext_cnt_nxt;
    end
  end

  // Two timers share the reload; only the receive copy is ever forced.
  asp_baud_timer u_tx_timer (
    .clk          (sys_clk),
    .rst_n        (rst_n_s),
    .ce           (clk_en),
    .run          (tmr_cfg.run),
    .tick         (tmr_tick),
    .reload       (tmr_cfg.reload),
    .force_reload (1'b0),
    .bit_tick_r   (tx_bit_r)
  );

  asp_baud_timer u_rx_timer (
    .clk          (sys_clk),
    .rst_n        (rst_n_s),
    .ce           (clk_en),
    .run          (tmr_cfg.run),
    .tick         (tmr_tick),
    .reload       (tmr_cfg.reload),
    .force_reload (rx_force),
    .bit_tick_r   (rx_bit_r)
  );

  assign tx_tick = tx_bit_r && clk_en;
  assign rx_tick = rx_bit_r && clk_en;

  // Transmitter; a buffer write while busy is dropped.
  always_comb begin
    tx_st_nxt   = tx_st_r;
    tx_sh_nxt   = tx_sh_r;
    tx_nine_nxt = tx_nine_r;
    tx_mode_nxt = tx_mode_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_set_ti   = 1'b0;
    case (tx_st_r)
      TX_IDLE: begin
        if (buf_wr) begin
          tx_sh_nxt   = buf_wdata;
          tx_nine_nxt = ctl_r.tb8;
          tx_mode_nxt = ctl_r.mode;
          tx_st_nxt   = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tx_tick) begin
          tx_st_nxt = TX_START;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          tx_cnt_nxt = 4'h0;
          tx_st_nxt  = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
          tx_cnt_nxt = tx_cnt_r + 4'h1;
          if (tx_cnt_r == LAST_DATA) begin
            tx_st_nxt = tx_mode_r ? TX_NINTH : TX_STOP;
            tx_set_ti = !tx_mode_r;
          end
        end
      end
      TX_NINTH: begin
        if (tx_tick) begin
          tx_st_nxt = TX_STOP;
          tx_set_ti = 1'b1;
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          tx_st_nxt = TX_IDLE;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    case (tx_st_nxt)
      TX_START: tx_out_nxt = 1'b0;
      TX_DATA:  tx_out_nxt = tx_sh_nxt[0];
      TX_NINTH: tx_out_nxt = tx_nine_nxt;
      default:  tx_out_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tx_st_r        <= TX_IDLE;
      tx_sh_r        <= BUF_RST;
      tx_nine_r      <= 1'b0;
      tx_mode_r      <= 1'b0;
      tx_cnt_r       <= 4'h0;
      serial_out_pin <= 1'b1;
      tx_busy        <= 1'b0;
    end else if (clk_en) begin
      tx_st_r        <= tx_st_nxt;
      tx_sh_r        <= tx_sh_nxt;
      tx_nine_r      <= tx_nine_nxt;
      tx_mode_r      <= tx_mode_nxt;
      tx_cnt_r       <= tx_cnt_nxt;
      serial_out_pin <= tx_out_nxt;
      tx_busy        <= (tx_st_nxt != TX_IDLE);
    end
  end

  // Receiver; a glitch that reads high at mid start bit is dropped.
  always_comb begin
    rx_st_nxt   = rx_st_r;
    rx_sh_nxt   = rx_sh_r;
    rx_nine_nxt = rx_nine_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_force    = 1'b0;
    rx_done     = 1'b0;
    case (rx_st_r)
      RX_IDLE: begin
        if (ctl_r.ren && prev_r[2] && !rx_in && clk_en) begin
          rx_force  = 1'b1;
          rx_st_nxt = RX_START;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          rx_cnt_nxt = 4'h0;
          rx_st_nxt  = rx_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_sh_nxt  = {rx_in, rx_sh_r[7:1]};
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r == LAST_DATA) begin
            rx_st_nxt = ctl_r.mode ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_NINTH: begin
        if (rx_tick) begin
          rx_nine_nxt = rx_in;
          rx_st_nxt   = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_done   = 1'b1;
          rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    rx_check  = ctl_r.mode ? rx_nine_r : rx_in;
    rx_accept = rx_done && !ctl_r.ri && (!ctl_r.filt || rx_check);
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rx_st_r   <= RX_IDLE;
      rx_sh_r   <= BUF_RST;
      rx_nine_r <= 1'b0;
      rx_cnt_r  <= 4'h0;
    end else if (clk_en) begin
      rx_st_r   <= rx_st_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_nine_r <= rx_nine_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
    end
  end

  // Hardware sets win over a software write in the same cycle.
  always_comb begin
    ctl_nxt  = ctl_r;
    hold_nxt = hold_r;
    if (ctl_wr) begin
      ctl_nxt = ctl_wdata;
    end
    ctl_nxt.one = 1'b1;
    if (tx_set_ti) begin
      ctl_nxt.ti = 1'b1;
    end
    if (rx_accept) begin
      ctl_nxt.ri  = 1'b1;
      ctl_nxt.rb8 = rx_check;
      hold_nxt    = rx_sh_r;
    end
    irq_nxt = irq_en && (ctl_nxt.ti || ctl_nxt.ri);
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctl_r   <= CTL_RST;
      hold_r  <= BUF_RST;
      irq_req <= 1'b0;
    end else if (clk_en) begin
      ctl_r   <= ctl_nxt;
      hold_r  <= hold_nxt;
      irq_req <= irq_nxt;
    end
  end

  assign serial_control_reg = ctl_r;
  assign serial_buffer_reg  = hold_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_s);

  a_bit6_reads_one: assert property (ctl_r.one)
    else $error("control bit 6 is not one");
  a_ti_sticky: assert property (ctl_r.ti && !ctl_wr |=> ctl_r.ti)
    else $error("transmit-done cleared without write");
  a_ri_sticky: assert property (ctl_r.ri && !ctl_wr |=> ctl_r.ri)
    else $error("receive-done cleared without write");
  a_accept_loads: assert property (rx_accept && clk_en |=>
      ctl_r.ri && hold_r == $past(rx_sh_r))
    else $error("accepted frame not loaded");
  a_reject_keeps: assert property (rx_done && !rx_accept && !ctl_wr |=>
      $stable(hold_r) && $stable(ctl_r.rb8))
    else $error("rejected frame changed holding data");
  a_irq_follows: assert property (clk_en && irq_en && (ctl_r.ti || ctl_r.ri)
      && !ctl_wr |=> irq_req)
    else $error("interrupt request missing");
  a_start_low: assert property (tx_st_r == TX_START |-> !serial_out_pin)
    else $error("start bit not low");
  a_ti_at_stop: assert property ($rose(tx_st_r == TX_STOP) |-> ctl_r.ti)
    else $error("transmit-done not set at stop start");
  a_ren_gate: assert property (rx_st_r == RX_IDLE && !ctl_r.ren |=>
      rx_st_r == RX_IDLE)
    else $error("reception began while disabled");
  a_nine_stored: assert property (rx_accept && clk_en && ctl_r.mode |=>
      ctl_r.rb8 == $past(rx_nine_r))
    else $error("ninth bit not stored");

  c_rx_accept: cover property (rx_accept && ctl_r.mode);
  c_rx_overrun: cover property (rx_done && ctl_r.ri);
  c_tx_stop: cover property ($rose(tx_st_r == TX_STOP));
  c_full_duplex: cover property (tx_st_r == TX_DATA && rx_st_r == RX_DATA);

endmodule
`default_nettype wire

// ---- dv/asp_remote_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
// Far-end serial peer: sends frames on the device's receive line and
// captures whatever the device puts on its transmit line.
module asp_remote_peer #(
  parameter int BIT = 16
) (
  input  wire logic        clk,
  input  wire logic        nine,
  input  wire logic        line_in,
  output var  logic        line_out,
  output var  logic [10:0] rx_bits,
  output var  int          rx_cnt
);
  initial begin
    line_out = 1'b1;
  end

  // Bits go out LSB first, one bit time each; caller starts just after an edge.
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out = f[i];
      repeat (BIT) @(posedge clk);
      #1;
    end
    line_out = 1'b1;
  endtask

  // Sampling on the falling clock edge keeps clear of the device's own updates.
  initial begin
    rx_bits = 11'h000;
    rx_cnt = 0;
    forever begin
      @(negedge line_in);
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
        repeat (i == 0 ? BIT / 2 : BIT) @(negedge clk);
        rx_bits[i] = line_in;
      end
      rx_cnt++;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_asp_serial_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_asp_serial_port;
  import asp_pkg::*;
  logic         sys_clk, reset_n, clk_en, ctl_wr, buf_wr, irq_en;
  logic         ext_osc_in, timer_ext_input, line_rx, line_tx, irq_req, tx_busy, nine_mode;
  asp_ctl_t     ctl_wdata, ctl_q;
  asp_tmr_cfg_t tmr_cfg;
  logic [7:0]   buf_wdata, buf_q;
  logic [10:0]  peer_bits;
  int           peer_cnt, failures, cmp_count, n;
  logic [2:0]   srcs[6] = '{SRC_DIV4, SRC_DIV12, SRC_DIV48, SRC_EXT8, SRC_PIN, SRC_SYS};
  int           mults[6] = '{4, 12, 48, 64, 8, 1};

  asp_serial_port dut (
    .sys_clk            (sys_clk),
    .reset_n            (reset_n),
    .clk_en             (clk_en),
    .ctl_wr             (ctl_wr),
    .ctl_wdata          (ctl_wdata),
    .buf_wr             (buf_wr),
    .buf_wdata          (buf_wdata),
    .tmr_cfg            (tmr_cfg),
    .irq_en             (irq_en),
    .ext_osc_in         (ext_osc_in),
    .timer_ext_input    (timer_ext_input),
    .serial_in_pin      (line_rx),
    .serial_out_pin     (line_tx),
    .serial_control_reg (ctl_q),
    .serial_buffer_reg  (buf_q),
    .irq_req            (irq_req),
    .tx_busy            (tx_busy)
  );

  asp_remote_peer #(.BIT(16)) peer (
    .clk      (sys_clk),
    .nine     (nine_mode),
    .line_in  (line_tx),
    .line_out (line_rx),
    .rx_bits  (peer_bits),
    .rx_cnt   (peer_cnt)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Slow external clocks with a period of eight system cycles.
  initial begin
    ext_osc_in = 1'b0;
    timer_ext_input = 1'b0;
    forever begin
      repeat (4) @(posedge sys_clk);
      #1;
      ext_osc_in = ~ext_osc_in;
      timer_ext_input = ~timer_ext_input;
    end
  end

  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic ctl_write(input logic [7:0] v);
    cycles(1);
    ctl_wdata = v;
    ctl_wr = 1'b1;
    cycles(1);
    ctl_wr = 1'b0;
    cycles(1);
  endtask

  task automatic buf_write(input logic [7:0] v);
    cycles(1);
    buf_wdata = v;
    buf_wr = 1'b1;
    cycles(1);
    buf_wr = 1'b0;
  endtask

  task automatic peer_send(input logic [10:0] f, input int k);
    peer.send(f, k);
    cycles(3);
  endtask

  // Sends one byte; bit time is two timer periods of (256 - reload) source ticks.
  task automatic tx_frame(input logic [7:0] d, input int mult, input int nb);
    int t;
    int w;
    int b;
    b = 16 * mult;
    w = 0;
    buf_write(d);
    for (t = 0; line_tx !== 1'b0 && t < 20000; t++) cycles(1);
    for (t = 0; ctl_q.ti !== 1'b1 && t < 40000; t++) begin
      cycles(1);
      if (w == 0 && line_tx === 1'b1) w = t + 1;
    end
    check("start width", 11'(w), 11'(b));
    check("done at stop", 1'(t >= nb * b - 1 && t <= nb * b + 2), 1'b1);
    cycles(1);
    check("irq", irq_req, irq_en);
    for (t = 0; tx_busy !== 1'b0 && t < 20000; t++) cycles(1);
    check("tx idle", tx_busy, 1'b0);
    check("ti held", ctl_q.ti, 1'b1);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end

  initial begin
    {ctl_wr, buf_wr, ctl_wdata, buf_wdata, reset_n, nine_mode} = '0;
    {clk_en, irq_en} = 2'h2;
    failures = 0;
    cmp_count = 0;
    tmr_cfg = {1'b1, SRC_SYS, 8'hf8};
    cycles(5);
    reset_n = 1'b1;
    cycles(3);
    check("ctl reset", ctl_q, 8'h40);
    check("buf reset", buf_q, 8'h00);
    check("idle line", {line_tx, irq_req, tx_busy}, 3'h4);
    ctl_write(8'h10);
    check("bit6", ctl_q, 8'h50);
    for (int i = 0; i < 6; i++) begin
      tmr_cfg.src = srcs[i];
      irq_en = (i != 0);
      tx_frame(8'h35, mults[i], 9);
      ctl_write(8'h10);
      check("ti cleared", {ctl_q.ti, irq_req}, 2'h0);
    end
    check("tx frame", peer_bits[9:0], {1'b1, 8'h35, 1'b0});
    n = peer_cnt;
    // Transmit and receive overlap; a second buffer write during busy is dropped.
    fork
      tx_frame(8'h35, 1, 9);
      begin
        cycles(6);
        buf_write(8'h99);
      end
      peer_send({1'b1, 8'h3c, 1'b0}, 10);
    join
    cycles(3);
    check("one frame", 11'(peer_cnt - n), 11'h1);
    check("rx byte", buf_q, 8'h3c);
    check("rx ctl", ctl_q, 8'h57);
    peer_send({1'b1, 8'h55, 1'b0}, 10);
    check("overrun", {ctl_q, buf_q}, {8'h57, 8'h3c});
    ctl_write(8'h34);
    peer_send({1'b0, 8'h66, 1'b0}, 10);
    check("bad stop", {ctl_q, buf_q}, {8'h74, 8'h3c});
    peer_send({1'b1, 8'h66, 1'b0}, 10);
    check("good stop", {ctl_q, buf_q}, {8'h75, 8'h66});
    ctl_write(8'h10);
    peer_send({1'b0, 8'h0f, 1'b0}, 10);
    check("stop to bit2", {ctl_q, buf_q}, {8'h51, 8'h0f});
    ctl_write(8'h20);
    peer_send({1'b1, 8'h11, 1'b0}, 10);
    check("rx off", {ctl_q, buf_q}, {8'h60, 8'h0f});
    nine_mode = 1'b1;
    ctl_write(8'hb8);
    tx_frame(8'h35, 1, 10);
    check("nine tx", peer_bits, {2'h3, 8'h35, 1'b0});
    check("nine ctl", ctl_q, 8'hfa);
    ctl_write(8'hb0);
    peer_send({1'b1, 1'b0, 8'h5a, 1'b0}, 11);
    check("ninth low", {ctl_q, buf_q}, {8'hf0, 8'h0f});
    peer_send({1'b0, 1'b1, 8'h5a, 1'b0}, 11);
    check("ninth high", {ctl_q, buf_q}, {8'hf5, 8'h5a});
    report_and_stop();
  end
endmodule
`default_nettype wire
